// >>> dbg_brk_slot.sv
// one hardware breakpoint slot: stored address, enable and comparator
// assumes load strobes come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module dbg_brk_slot
  import dbg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // load
  input wire logic load,
  input wire logic load_en,
  input wire logic [ADDR_W-1:0] load_addr,
  // compare
  input wire logic [ADDR_W-1:0] code_addr,
  output logic hit
);
  logic en_reg;
  logic [ADDR_W-1:0] addr_reg;

  // slot contents, cleared at reset so no stray halt appears
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      en_reg <= 1'b0;
      addr_reg <= '0;
    end
    else if (load)
    begin
      en_reg <= load_en;
      addr_reg <= load_addr;
    end
  end

  // continuous comparison against the code address bus
  assign hit = en_reg && (addr_reg == code_addr);
endmodule
`default_nettype wire

// >>> dbg_core.sv
// debug configuration byte, status byte and four code breakpoints
// assumes the serial front end delivers command and data bytes as one-cycle strobes on CLK,
// and that CPU side status inputs are synchronous to CLK except the oscillator flags
`timescale 1ns/1ps
`default_nettype none
module dbg_core
  import dbg_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // host byte stream from the transport
  input wire logic CMD_VALID,
  input wire logic DATA_VALID,
  input wire logic [7:0] RX_BYTE,
  output logic TX_VALID,
  output logic [7:0] TX_BYTE,
  // cpu and system status
  input wire logic [ADDR_W-1:0] CODE_ADDR,
  input wire logic DATA_WR,
  input wire logic [7:0] DATA_WADDR,
  input wire logic ERASE_BUSY,
  input wire logic CORE_CLOCK_GATED,
  input wire logic DEBUG_LOCK_FUSE,
  input wire logic CRYSTAL_SETTLED,
  input wire logic RC_SETTLED,
  input wire logic [1:0] POWER_MODE,
  input wire logic WAKE_EVENT,
  input wire logic DEBUGGING,
  // controls to the system
  output logic CPU_HALT,
  output logic TIMER_STOP,
  output logic TIMER_HOLD,
  output logic DMA_HOLD,
  output logic INFO_REGION_SELECT,
  output logic CORE_REG_ON,
  output logic FAST_OSC_ON,
  output logic SLOW_OSC_ON,
  // cpu activity qualifiers for timer suspend
  input wire logic INJECTED_INSTR,
  input wire logic STEPPED_BRANCH
);
  typedef enum logic [1:0]
  {
    RX_CMD = 2'b00,
    RX_CFG = 2'b01,
    RX_BRK = 2'b10
  } rx_state_type;

  rx_state_type rx_state_reg;
  logic [1:0] brk_cnt_reg;
  logic [7:0] brk_b0_reg;
  logic [7:0] brk_b1_reg;
  logic [7:0] debug_configuration_byte_reg;
  logic halted_reg;
  logic halt_cause_reg;
  logic stack_reg;
  logic wake_stop_reg;
  logic [1:0] osc_meta_reg;
  logic [1:0] osc_sync_reg;
  logic [7:0] debug_status_byte;
  logic [BRK_SLOTS-1:0] hit;
  logic any_hit;
  logic enabled;
  logic brk_last;
  logic cmd_halt;
  logic cmd_resume;
  logic stack_hit;

  // lock bit low means every command is ignored, including reads
  assign enabled = DEBUG_LOCK_FUSE;
  assign brk_last = (rx_state_reg == RX_BRK) && DATA_VALID && (brk_cnt_reg == 2'd2);
  assign cmd_halt = enabled && CMD_VALID && (rx_state_reg == RX_CMD) && (RX_BYTE == CMD_HALT);
  assign cmd_resume = enabled && CMD_VALID && (rx_state_reg == RX_CMD) && (RX_BYTE == CMD_RESUME);

  // receive sequencer: decides which data bytes belong to which command
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      rx_state_reg <= RX_CMD;
      brk_cnt_reg <= 2'd0;
    end
    else
    begin
      case (rx_state_reg)
        RX_CMD:
        begin
          if (enabled && CMD_VALID && RX_BYTE == CMD_WR_CONFIG)
            rx_state_reg <= RX_CFG;
          else if (enabled && CMD_VALID && RX_BYTE == CMD_SET_BRK)
          begin
            rx_state_reg <= RX_BRK;
            brk_cnt_reg <= 2'd0;
          end
        end
        RX_CFG:
        begin
          if (DATA_VALID)
            rx_state_reg <= RX_CMD;
        end
        RX_BRK:
        begin
          if (DATA_VALID)
          begin
            brk_cnt_reg <= brk_cnt_reg + 2'd1;
            if (brk_cnt_reg == 2'd2)
              rx_state_reg <= RX_CMD;
          end
        end
        default:
          rx_state_reg <= RX_CMD;
      endcase
    end
  end

  // breakpoint bytes are staged until the third one completes the set
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      brk_b0_reg <= 8'h00;
      brk_b1_reg <= 8'h00;
    end
    else if (rx_state_reg == RX_BRK && DATA_VALID)
    begin
      if (brk_cnt_reg == 2'd0)
        brk_b0_reg <= RX_BYTE;
      if (brk_cnt_reg == 2'd1)
        brk_b1_reg <= RX_BYTE;
    end
  end

  // configuration byte; unused upper bits are masked so stray host ones do nothing
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      debug_configuration_byte_reg <= CFG_RESET;
    else if (rx_state_reg == RX_CFG && DATA_VALID)
      debug_configuration_byte_reg <= RX_BYTE & CFG_USED_MASK;
  end

  // breakpoint slots, one per generate entry
  genvar g;
  generate
    for (g = 0; g < BRK_SLOTS; g = g + 1)
    begin : slot
      dbg_brk_slot u_slot
      (
        .clk(CLK),
        .rst_n(RST_N),
        .load(brk_last && (brk_b0_reg[BRK_SLOT_HI:BRK_SLOT_LO] == 2'(g))),
        .load_en(brk_b0_reg[BRK_EN_BIT]),
        .load_addr({brk_b0_reg[1:0], brk_b1_reg, RX_BYTE}),
        .code_addr(CODE_ADDR),
        .hit(hit[g])
      );
    end
  endgenerate

  assign any_hit = |hit;

  // halt state; while running, a breakpoint wins over a halt command in the same cycle
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      halted_reg <= 1'b0;
      halt_cause_reg <= 1'b0;
    end
    else if (any_hit && !halted_reg)
    begin
      halted_reg <= 1'b1;
      halt_cause_reg <= 1'b1;
    end
    else if (cmd_halt)
    begin
      halted_reg <= 1'b1;
      halt_cause_reg <= 1'b0;
    end
    else if (cmd_resume && halted_reg)
      halted_reg <= 1'b0;
  end

  // waking from timed or deep sleep under debug stops the chip until halt then resume
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      wake_stop_reg <= 1'b0;
    else if (DEBUGGING && WAKE_EVENT && (POWER_MODE == PM_TIMED || POWER_MODE == PM_DEEP))
      wake_stop_reg <= 1'b1;
    else if (cmd_resume && halted_reg)
      wake_stop_reg <= 1'b0;
  end

  // sticky stack flag; nothing here clears it apart from reset
  assign stack_hit = DATA_WR && (DATA_WADDR == STACK_ADDR);
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      stack_reg <= 1'b0;
    else if (stack_hit)
      stack_reg <= 1'b1;
  end

  // oscillator flags come from the analog domain, so each gets two flops of its own;
  // combining them before the flops could let a glitch through
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      osc_meta_reg <= 2'b00;
      osc_sync_reg <= 2'b00;
    end
    else
    begin
      osc_meta_reg <= {CRYSTAL_SETTLED, RC_SETTLED};
      osc_sync_reg <= osc_meta_reg;
    end
  end

  // status byte assembly
  always_comb
  begin
    debug_status_byte = 8'h00;
    debug_status_byte[ST_ERASE_DONE] = !ERASE_BUSY;
    debug_status_byte[ST_IDLE] = CORE_CLOCK_GATED;
    debug_status_byte[ST_HALTED] = halted_reg;
    debug_status_byte[ST_ACTIVE] = (POWER_MODE == PM_ACTIVE);
    debug_status_byte[ST_HALT_CAUSE] = halt_cause_reg;
    debug_status_byte[ST_LOCKED] = DEBUG_LOCK_FUSE;
    debug_status_byte[ST_OSC] = &osc_sync_reg;
    debug_status_byte[ST_STACK] = stack_reg;
  end

  // read answers, one cycle after the command strobe
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      TX_VALID <= 1'b0;
      TX_BYTE <= 8'h00;
    end
    else
    begin
      TX_VALID <= 1'b0;
      if (enabled && CMD_VALID && rx_state_reg == RX_CMD)
      begin
        if (RX_BYTE == CMD_RD_CONFIG)
        begin
          TX_VALID <= 1'b1;
          TX_BYTE <= debug_configuration_byte_reg;
        end
        else if (RX_BYTE == CMD_RD_STATUS)
        begin
          TX_VALID <= 1'b1;
          TX_BYTE <= debug_status_byte;
        end
      end
    end
  end

  // system controls; injected instructions are the host's route to flash programming
  assign CPU_HALT = halted_reg || wake_stop_reg;
  assign TIMER_STOP = debug_configuration_byte_reg[CFG_TIMERS_OFF];
  assign TIMER_HOLD = debug_configuration_byte_reg[CFG_TIMERS_OFF]
    || (debug_configuration_byte_reg[CFG_SUSPEND] && (INJECTED_INSTR || STEPPED_BRANCH));
  assign DMA_HOLD = debug_configuration_byte_reg[CFG_DMA_PAUSE];
  assign INFO_REGION_SELECT = debug_configuration_byte_reg[CFG_INFO];
  assign CORE_REG_ON = DEBUGGING || POWER_MODE == PM_ACTIVE || POWER_MODE == PM_LIGHT;
  assign FAST_OSC_ON = (POWER_MODE == PM_ACTIVE);
  assign SLOW_OSC_ON = (POWER_MODE != PM_DEEP);

  // breakpoint halt reflected in status within one cycle
  halt_on_hit_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (any_hit && !halted_reg) |=> (halted_reg && halt_cause_reg)) else $error("breakpoint did not halt");
  cmd_halt_cause_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (cmd_halt && !(any_hit && !halted_reg)) |=> (halted_reg && !halt_cause_reg)) else $error("halt cause wrong");
  cfg_upper_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
    debug_configuration_byte_reg[7:4] == 4'h0) else $error("config upper bits set");
  cfg_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (rx_state_reg == RX_CFG && DATA_VALID) |=> (debug_configuration_byte_reg == ($past(RX_BYTE) & CFG_USED_MASK)))
    else $error("config write lost");
  timer_priority_a: assert property (@(posedge CLK) disable iff (!RST_N)
    TIMER_STOP |-> TIMER_HOLD) else $error("timer stop not dominant");
  stack_sticky_a: assert property (@(posedge CLK) disable iff (!RST_N)
    stack_hit |=> stack_reg [*2]) else $error("stack flag not sticky");
  locked_ignore_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !DEBUG_LOCK_FUSE |=> !TX_VALID) else $error("locked interface answered");
  status_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (enabled && CMD_VALID && rx_state_reg == RX_CMD && RX_BYTE == CMD_RD_STATUS) |=>
    (TX_VALID && TX_BYTE[ST_HALTED] == $past(halted_reg))) else $error("status read wrong");
  brk_count_a: assert property (@(posedge CLK) disable iff (!RST_N)
    brk_last |=> rx_state_reg == RX_CMD) else $error("breakpoint byte count wrong");
endmodule
`default_nettype wire

// >>> dbg_host_model.sv
// debug host model: sends command and data bytes and collects read answers
// assumes the byte strobes of dbg_core sampled on clk, one byte every two cycles
`timescale 1ns/1ps
`default_nettype none
module dbg_host_model
  import dbg_pkg::*;
(
  // clock
  input wire logic clk,
  // byte stream
  output logic cmd_valid,
  output logic data_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte
);
  // idle at time zero
  initial
  begin
    cmd_valid = 1'b0;
    data_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // one strobed byte; the idle byte shows the inverse so stale data never passes for fresh
  task automatic put(input logic is_cmd, input logic [7:0] b);
    @(posedge clk);
    cmd_valid <= is_cmd;
    data_valid <= !is_cmd;
    rx_byte <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    data_valid <= 1'b0;
    rx_byte <= ~b;
  endtask
  // the answer stands only in the cycle after the command edge
  task automatic rd(input logic [7:0] c, output logic v, output logic [7:0] b);
    put(1'b1, c);
    #1;
    v = tx_valid;
    b = tx_byte;
  endtask
  // unused upper nibble always sent as zero
  task automatic wr_cfg(input logic [3:0] c);
    put(1'b1, CMD_WR_CONFIG);
    put(1'b0, {4'h0, c});
  endtask
  // breakpoint command then exactly three data bytes
  task automatic brk(input logic [1:0] s, input logic en, input logic [17:0] a);
    put(1'b1, CMD_SET_BRK);
    put(1'b0, {3'b000, s, en, a[17:16]});
    put(1'b0, a[15:8]);
    put(1'b0, a[7:0]);
  endtask
endmodule
`default_nettype wire

// >>> dbg_pkg.sv
// constants for the debug configuration, status and breakpoint block
// assumes one system clock and a byte-wide command/data strobe from the serial front end
`default_nettype none
package dbg_pkg;
  localparam logic [7:0] CMD_WR_CONFIG = 8'h19;
  localparam logic [7:0] CMD_RD_CONFIG = 8'h24;
  localparam logic [7:0] CMD_RD_STATUS = 8'h30;
  localparam logic [7:0] CMD_SET_BRK = 8'h3f;
  localparam logic [7:0] CMD_HALT = 8'h44;
  localparam logic [7:0] CMD_RESUME = 8'h4c;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_USED_MASK = 8'h0f;
  localparam int CFG_TIMERS_OFF = 3;
  localparam int CFG_DMA_PAUSE = 2;
  localparam int CFG_SUSPEND = 1;
  localparam int CFG_INFO = 0;
  localparam int ST_ERASE_DONE = 7;
  localparam int ST_IDLE = 6;
  localparam int ST_HALTED = 5;
  localparam int ST_ACTIVE = 4;
  localparam int ST_HALT_CAUSE = 3;
  localparam int ST_LOCKED = 2;
  localparam int ST_OSC = 1;
  localparam int ST_STACK = 0;
  localparam int BRK_SLOTS = 4;
  localparam int ADDR_W = 18;
  localparam int BRK_SLOT_HI = 4;
  localparam int BRK_SLOT_LO = 3;
  localparam int BRK_EN_BIT = 2;
  localparam logic [7:0] STACK_ADDR = 8'hff;
  localparam logic [1:0] PM_ACTIVE = 2'h0;
  localparam logic [1:0] PM_LIGHT = 2'h1;
  localparam logic [1:0] PM_TIMED = 2'h2;
  localparam logic [1:0] PM_DEEP = 2'h3;
endpackage
`default_nettype wire

// >>> tb_dbg_core.sv
// testbench for dbg_core: host model drives bytes, bench drives the cpu side
// assumes 40 MHz CLK and synchronous active low reset held 12 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_dbg_core
  import dbg_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cv, dv, txv, data_wr, erase_busy, idle, fuse, xtal, rc, wake, dbg, inj, stp, v1, en;
  logic halt, t_stop, t_hold, dma, info, reg_on, fast_on, slow_on;
  logic [7:0] rxb, txb, waddr, v8;
  logic [1:0] mode;
  logic [3:0] c;
  logic [17:0] code_addr, a;
  logic [3:0] cfgs [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'ha, 4'h0};
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  dbg_core u_dut (.CLK(clk), .RST_N(rst_n), .CMD_VALID(cv), .DATA_VALID(dv), .RX_BYTE(rxb),
    .TX_VALID(txv), .TX_BYTE(txb), .CODE_ADDR(code_addr), .DATA_WR(data_wr), .DATA_WADDR(waddr),
    .ERASE_BUSY(erase_busy), .CORE_CLOCK_GATED(idle), .DEBUG_LOCK_FUSE(fuse), .CRYSTAL_SETTLED(xtal),
    .RC_SETTLED(rc), .POWER_MODE(mode), .WAKE_EVENT(wake), .DEBUGGING(dbg), .CPU_HALT(halt),
    .TIMER_STOP(t_stop), .TIMER_HOLD(t_hold), .DMA_HOLD(dma), .INFO_REGION_SELECT(info),
    .CORE_REG_ON(reg_on), .FAST_OSC_ON(fast_on), .SLOW_OSC_ON(slow_on), .INJECTED_INSTR(inj),
    .STEPPED_BRANCH(stp));
  dbg_host_model u_host (.clk(clk), .cmd_valid(cv), .data_valid(dv), .rx_byte(rxb),
    .tx_valid(txv), .tx_byte(txb));

  // 25 ns clock
  always #12.5 clk = ~clk;
  // a hang counts as a miscompare
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // status expected from the bench's own inputs
  task automatic chk_st(input logic h, input logic k, input logic s);
    u_host.rd(CMD_RD_STATUS, v1, v8);
    `CHK("status answer", 1'b1, v1)
    `CHK("status", {!erase_busy, idle, h, mode == PM_ACTIVE, k, fuse, xtal & rc, s}, v8)
  endtask

  initial
  begin
    {data_wr, erase_busy, idle, wake, dbg, inj, stp, xtal, rc} = '0;
    fuse = 1'b1;
    mode = PM_ACTIVE;
    waddr = 8'h00;
    code_addr = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    u_host.rd(CMD_RD_CONFIG, v1, v8);
    `CHK("cfg reset", CFG_RESET, v8)
    // config values, timer hold under each cpu qualifier
    for (int i = 0; i < 6; i++)
    begin
      c = cfgs[i];
      u_host.wr_cfg(c);
      u_host.rd(CMD_RD_CONFIG, v1, v8);
      `CHK("cfg", {4'h0, c}, v8)
      `CHK("tstop", c[3], t_stop)
      `CHK("dma", c[2], dma)
      `CHK("info", c[0], info)
      for (int j = 0; j < 3; j++)
      begin
        @(posedge clk);
        inj <= (j == 1);
        stp <= (j == 2);
        tick(0);
        `CHK("thold", c[3] | (c[1] & (j != 0)), t_hold)
      end
    end
    chk_st(1'b0, 1'b0, 1'b0);
    // near-address write, one settled oscillator
    @(posedge clk);
    {erase_busy, idle, xtal, data_wr} <= 4'hf;
    mode <= PM_LIGHT;
    waddr <= 8'hfe;
    tick(4);
    chk_st(1'b0, 1'b0, 1'b0);
    @(posedge clk);
    {rc, data_wr} <= 2'b11;
    waddr <= STACK_ADDR;
    @(posedge clk);
    data_wr <= 1'b0;
    tick(3);
    chk_st(1'b0, 1'b0, 1'b1);
    // regulator and oscillators per mode, with and without a debug session
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      mode <= k[1:0];
      dbg <= k[2];
      tick(0);
      `CHK("reg", k[2] || k[1:0] < 2, reg_on)
      `CHK("fast", k[1:0] == 0, fast_on)
      `CHK("slow", k[1:0] != 3, slow_on)
    end
    @(posedge clk);
    {erase_busy, idle, dbg} <= 3'h0;
    mode <= PM_ACTIVE;
    // each slot halts on its own address only, and only while enabled
    for (int s = 0; s < 4; s++)
    begin
      a = 18'h2abc0 + s * 18'h1111;
      for (int e = 1; e >= 0; e--)
      begin
        en = e[0];
        u_host.brk(s[1:0], en, a);
        code_addr <= a ^ 18'h1;
        tick(2);
        `CHK("near miss", 1'b0, halt)
        @(posedge clk);
        code_addr <= a;
        tick(1);
        `CHK("bp halt", en, halt)
        if (en)
          chk_st(1'b1, 1'b1, 1'b1);
        @(posedge clk);
        code_addr <= '0;
        u_host.put(1'b1, CMD_RESUME);
      end
    end
    // halt command replaces the breakpoint cause
    u_host.put(1'b1, CMD_HALT);
    chk_st(1'b1, 1'b0, 1'b1);
    u_host.put(1'b1, CMD_RESUME);
    tick(1);
    `CHK("resume", 1'b0, halt)
    // waking from modes 2 and 3 stops the core until halt then resume
    for (int m = 1; m < 4; m++)
    begin
      @(posedge clk);
      dbg <= 1'b1;
      mode <= m[1:0];
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      mode <= PM_ACTIVE;
      tick(1);
      `CHK("wake stop", m > 1, halt)
      u_host.put(1'b1, CMD_HALT);
      u_host.put(1'b1, CMD_RESUME);
      tick(1);
      `CHK("wake resume", 1'b0, halt)
    end
    // mid-run reset returns the configuration to zero
    u_host.wr_cfg(4'hd);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick(0);
    `CHK("reset dma", 1'b0, dma)
    `CHK("reset tstop", 1'b0, t_stop)
    u_host.rd(CMD_RD_CONFIG, v1, v8);
    `CHK("cfg after reset", CFG_RESET, v8)
    // locked: no answer and no state change
    @(posedge clk);
    fuse <= 1'b0;
    u_host.wr_cfg(4'h4);
    u_host.rd(CMD_RD_CONFIG, v1, v8);
    `CHK("locked answer", 1'b0, v1)
    `CHK("locked cfg", 1'b0, dma)
    complete_run();
  end
endmodule
`default_nettype wire
